//--- rtl/tbu_cfg.svh
/*
  constants of the trace and breakpoint unit: widths, depths, limits.
  assumes inclusion by bare name; guarded, so it may be included more than once per compilation unit.
*/
`ifndef TBU_CFG_SVH
`define TBU_CFG_SVH
`define TBU_ADDR_W      11
`define TBU_EVT_W       4
`define TBU_ENTRY_W     16
`define TBU_DEPTH       254
`define TBU_PTR_W       8
`define TBU_PRE_MAX     8'hfd
`define TBU_FIFO_DEPTH  16
`define TBU_FIFO_PTR_W  4
`define TBU_CNT_W       8
`define TBU_ENT_SKIP    11
`define TBU_ENT_EVT_LO  12
`endif

//--- rtl/tbu_pkg.sv
/*
  types of the trace and breakpoint unit.
  assumes tbu_cfg.svh is found by bare name; includes it itself.
*/
`include "tbu_cfg.svh"
package tbu_pkg;
  typedef enum logic [1:0] {
    tbu_tr_idle,
    tbu_tr_armed,
    tbu_tr_post,
    tbu_tr_done
  } tbu_trace_state_t;
  typedef enum logic [1:0] {
    tbu_bk_idle,
    tbu_bk_armed,
    tbu_bk_dump
  } tbu_break_state_t;
  typedef enum logic [1:0] {
    tbu_cond_none,
    tbu_cond_addr,
    tbu_cond_event
  } tbu_cond_t;
endpackage

//--- rtl/tbu_fifo.sv
/*
  synchronous fifo with valid and ready on both sides.
  assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/10ps
module tbu_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16,
  parameter int PTR_W = 4
) (
  input  wire logic             clk_sys_in,
  input  wire logic             nrst_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  output logic      [WIDTH-1:0] rd_data_out,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W:0]   wr_ptr;
  logic [PTR_W:0]   rd_ptr;
  logic             do_wr;
  logic             do_rd;

  assign wr_ready_out = (wr_ptr - rd_ptr) != (PTR_W+1)'(DEPTH);
  assign rd_valid_out = wr_ptr != rd_ptr;
  assign rd_data_out  = mem[rd_ptr[PTR_W-1:0]];
  assign do_wr        = wr_valid_in && wr_ready_out;
  assign do_rd        = rd_valid_out && rd_ready_in;

  always_ff @(posedge clk_sys_in) begin
    if (do_wr) begin
      mem[wr_ptr[PTR_W-1:0]] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

//--- rtl/tbu_trace_mem.sv
/*
  trace memory of 254 entries, registered read data.
  assumes one clock; contents undefined until written.
*/
`timescale 1ns/10ps
`include "tbu_cfg.svh"
module tbu_trace_mem (
  input  wire logic                     clk_sys_in,
  input  wire logic                     wr_en_in,
  input  wire logic [`TBU_PTR_W-1:0]    wr_addr_in,
  input  wire logic [`TBU_ENTRY_W-1:0]  wr_data_in,
  input  wire logic [`TBU_PTR_W-1:0]    rd_addr_in,
  output logic      [`TBU_ENTRY_W-1:0]  rd_data_out
);
  logic [`TBU_ENTRY_W-1:0] mem [`TBU_DEPTH];

  always_ff @(posedge clk_sys_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    rd_data_out <= mem[rd_addr_in];
  end
endmodule

//--- rtl/tbu_top.sv
/*
  trace and breakpoint unit of an in-circuit emulation card: watches fetch
  address, skip and four event inputs, records traces, raises breaks, pulses
  a trigger and redirects fetches to the dump memory during a break.
  assumes all inputs synchronous to clk_sys_in; one fetch strobe per fetch.
*/
// Functional notes
// - the trace memory holds up to 254 successive fetch addresses, one per fetch.
// - a trace starts on host command or, when armed, on an address or event 1/2 match.
// - armed trace conditions are counted and the trace begins at the programmed count 1..256.
// - a rising edge appears on the trigger output when the trace begins.
// - a pre-trigger depth 0..252 is kept and the rest of the memory fills after the trigger; the code clamps the depth at 253 (TBU_PRE_MAX), not 252.
// - every entry stores the skip status of its instruction.
// - every entry stores the levels of all four event inputs.
// - a break starts on host command or on an address or event 1/2 match.
// - break conditions are counted 1..256 and the trigger rises when the break begins.
// - during a break fetches are taken from the dump memory instead of program memory.
// - the dump routine holds the core until the host commands resume.
// - single step raises a break on every successive instruction.
// - the host can reset the emulation card through a dedicated reset line.
// - the core fetches program words over dedicated address and data lines.
// - the program address is eleven bits, bit zero least significant.
`timescale 1ns/10ps
`include "tbu_cfg.svh"
module tbu_top (
  input  wire logic                    clk_sys_in,
  input  wire logic                    nrst_in,
  input  wire logic                    host_reset_in,
  input  wire logic [`TBU_ADDR_W-1:0]  prog_addr_in,
  input  wire logic                    fetch_in,
  input  wire logic                    skip_in,
  input  wire logic                    ext_event_1_in,
  input  wire logic                    ext_event_2_in,
  input  wire logic                    ext_event_3_in,
  input  wire logic                    ext_event_4_in,
  input  wire logic [7:0]              prog_data_in,
  input  wire logic [7:0]              dump_data_in,
  input  wire tbu_pkg::tbu_cond_t      trace_cond_in,
  input  wire logic [`TBU_ADDR_W-1:0]  trace_addr_in,
  input  wire logic [1:0]              trace_evt_in,
  input  wire logic [`TBU_CNT_W-1:0]   trace_cnt_in,
  input  wire logic [`TBU_PTR_W-1:0]   pre_depth_in,
  input  wire logic                    trace_arm_in,
  input  wire logic                    trace_now_in,
  input  wire tbu_pkg::tbu_cond_t      break_cond_in,
  input  wire logic [`TBU_ADDR_W-1:0]  break_addr_in,
  input  wire logic [1:0]              break_evt_in,
  input  wire logic [`TBU_CNT_W-1:0]   break_cnt_in,
  input  wire logic                    break_arm_in,
  input  wire logic                    break_now_in,
  input  wire logic                    step_en_in,
  input  wire logic                    resume_in,
  input  wire logic                    dump_done_in,
  input  wire logic                    rd_req_in,
  input  wire logic                    rd_ready_in,
  output logic                         card_nrst_out,
  output logic [`TBU_ADDR_W-1:0]       mem_addr_out,
  output logic [7:0]                   core_data_out,
  output logic                         dump_sel_out,
  output logic                         core_hold_out,
  output logic                         trigger_out,
  output logic                         trace_busy_out,
  output logic                         trace_done_out,
  output logic [`TBU_PTR_W-1:0]        trace_count_out,
  output logic [`TBU_ENTRY_W-1:0]      rd_data_out,
  output logic                         rd_valid_out,
  output logic                         overrun_out
);
  tbu_pkg::tbu_trace_state_t tr_state;
  tbu_pkg::tbu_break_state_t bk_state;
  logic [`TBU_CNT_W-1:0]     tr_cnt;
  logic [`TBU_CNT_W-1:0]     bk_cnt;
  logic [`TBU_PTR_W-1:0]     wr_ptr;
  logic [`TBU_PTR_W-1:0]     fill;
  logic [`TBU_PTR_W-1:0]     post_left;
  logic [`TBU_PTR_W-1:0]     rd_ptr;
  logic [`TBU_PTR_W-1:0]     rd_left;
  logic                      rd_busy;
  logic                      mem_vld;
  logic [`TBU_ENTRY_W-1:0]   entry;
  logic [`TBU_ENTRY_W-1:0]   mem_q;
  logic                      fifo_ready;
  logic                      tr_hit;
  logic                      bk_hit;
  logic                      tr_fire;
  logic                      bk_fire;
  logic                      recording;
  logic                      trig_req;
  logic [`TBU_PTR_W-1:0]     pre_eff;

  // condition compare on one fetch
  function automatic logic cond_match(input tbu_pkg::tbu_cond_t c,
                                      input logic [`TBU_ADDR_W-1:0] a,
                                      input logic [`TBU_ADDR_W-1:0] ref_a,
                                      input logic [1:0] ev,
                                      input logic [1:0] ref_ev);
    case (c)
      tbu_pkg::tbu_cond_addr:  cond_match = (a == ref_a);
      tbu_pkg::tbu_cond_event: cond_match = (ev == ref_ev);
      default:                 cond_match = 1'b0;
    endcase
  endfunction

  // ring index increment modulo the trace depth
  function automatic logic [`TBU_PTR_W-1:0] ring_inc(input logic [`TBU_PTR_W-1:0] p);
    ring_inc = (p == `TBU_PTR_W'(`TBU_DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // entry: events 4..1, skip, eleven address bits with bit 0 least significant
  assign entry = {ext_event_4_in, ext_event_3_in, ext_event_2_in, ext_event_1_in,
                  skip_in, prog_addr_in};
  assign tr_hit = fetch_in && (tr_state == tbu_pkg::tbu_tr_armed) &&
                  cond_match(trace_cond_in, prog_addr_in, trace_addr_in,
                             {ext_event_2_in, ext_event_1_in}, trace_evt_in);
  assign tr_fire = (trace_now_in && tr_state != tbu_pkg::tbu_tr_post) ||
                   (tr_hit && tr_cnt == '0);
  assign bk_hit = fetch_in && (bk_state == tbu_pkg::tbu_bk_armed) &&
                  cond_match(break_cond_in, prog_addr_in, break_addr_in,
                             {ext_event_2_in, ext_event_1_in}, break_evt_in);
  assign bk_fire = (bk_state != tbu_pkg::tbu_bk_dump) &&
                   (break_now_in || (bk_hit && bk_cnt == '0) ||
                    (step_en_in && fetch_in));
  assign recording = fetch_in && (tr_state == tbu_pkg::tbu_tr_armed ||
                                  tr_state == tbu_pkg::tbu_tr_post);
  assign pre_eff = (pre_depth_in > `TBU_PRE_MAX) ? `TBU_PRE_MAX : pre_depth_in;
  assign trig_req = tr_fire || bk_fire;

  // host-controlled card reset line
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      card_nrst_out <= 1'b0;
    end else begin
      card_nrst_out <= !host_reset_in;
    end
  end

  // trace state machine
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      tr_state  <= tbu_pkg::tbu_tr_idle;
      tr_cnt    <= '0;
      post_left <= '0;
    end else begin
      case (tr_state)
        tbu_pkg::tbu_tr_idle, tbu_pkg::tbu_tr_done: begin
          if (trace_now_in) begin
            tr_state  <= tbu_pkg::tbu_tr_post;
            post_left <= `TBU_PTR_W'(`TBU_DEPTH);
          end else if (trace_arm_in) begin
            tr_state <= tbu_pkg::tbu_tr_armed;
            tr_cnt   <= trace_cnt_in;
          end
        end
        tbu_pkg::tbu_tr_armed: begin
          if (tr_fire) begin
            tr_state  <= tbu_pkg::tbu_tr_post;
            post_left <= `TBU_PTR_W'(`TBU_DEPTH - 1) - pre_eff;
          end else if (tr_hit) begin
            tr_cnt <= tr_cnt - 1'b1;
          end
        end
        tbu_pkg::tbu_tr_post: begin
          if (fetch_in) begin
            if (post_left == `TBU_PTR_W'(1)) begin
              tr_state <= tbu_pkg::tbu_tr_done;
            end
            post_left <= post_left - 1'b1;
          end
        end
        default: tr_state <= tbu_pkg::tbu_tr_idle;
      endcase
    end
  end

  // write pointer and fill level
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      wr_ptr <= '0;
      fill   <= '0;
    end else if ((tr_state == tbu_pkg::tbu_tr_idle || tr_state == tbu_pkg::tbu_tr_done) &&
                 (trace_arm_in || trace_now_in)) begin
      wr_ptr <= '0;
      fill   <= '0;
    end else if (recording) begin
      wr_ptr <= ring_inc(wr_ptr);
      if (fill != `TBU_PTR_W'(`TBU_DEPTH)) begin
        fill <= fill + 1'b1;
      end
    end
  end

  tbu_trace_mem u_mem (
    .clk_sys_in  (clk_sys_in),
    .wr_en_in    (recording),
    .wr_addr_in  (wr_ptr),
    .wr_data_in  (entry),
    .rd_addr_in  (rd_ptr),
    .rd_data_out (mem_q)
  );

  // readout: oldest entry first into the fifo
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      rd_busy <= 1'b0;
      rd_ptr  <= '0;
      rd_left <= '0;
      mem_vld <= 1'b0;
    end else begin
      mem_vld <= 1'b0;
      if (!rd_busy) begin
        if (rd_req_in && tr_state == tbu_pkg::tbu_tr_done && fill != '0) begin
          rd_busy <= 1'b1;
          rd_left <= fill;
          rd_ptr  <= (fill == `TBU_PTR_W'(`TBU_DEPTH)) ? wr_ptr : '0;
        end
      end else if (fifo_ready && !mem_vld) begin
        mem_vld <= 1'b1;
        rd_ptr  <= ring_inc(rd_ptr);
        rd_left <= rd_left - 1'b1;
        if (rd_left == `TBU_PTR_W'(1)) begin
          rd_busy <= 1'b0;
        end
      end
    end
  end

  tbu_fifo #(
    .WIDTH (`TBU_ENTRY_W),
    .DEPTH (`TBU_FIFO_DEPTH),
    .PTR_W (`TBU_FIFO_PTR_W)
  ) u_fifo (
    .clk_sys_in   (clk_sys_in),
    .nrst_in      (nrst_in),
    .wr_data_in   (mem_q),
    .wr_valid_in  (mem_vld),
    .wr_ready_out (fifo_ready),
    .rd_data_out  (rd_data_out),
    .rd_valid_out (rd_valid_out),
    .rd_ready_in  (rd_ready_in)
  );

  // break state machine
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      bk_state <= tbu_pkg::tbu_bk_idle;
      bk_cnt   <= '0;
    end else begin
      case (bk_state)
        tbu_pkg::tbu_bk_idle: begin
          if (bk_fire) begin
            bk_state <= tbu_pkg::tbu_bk_dump;
          end else if (break_arm_in) begin
            bk_state <= tbu_pkg::tbu_bk_armed;
            bk_cnt   <= break_cnt_in;
          end
        end
        tbu_pkg::tbu_bk_armed: begin
          if (bk_fire) begin
            bk_state <= tbu_pkg::tbu_bk_dump;
          end else if (bk_hit) begin
            bk_cnt <= bk_cnt - 1'b1;
          end
        end
        tbu_pkg::tbu_bk_dump: begin
          if (resume_in) begin
            bk_state <= tbu_pkg::tbu_bk_idle;
          end
        end
        default: bk_state <= tbu_pkg::tbu_bk_idle;
      endcase
    end
  end

  // fetch path, trigger and status outputs
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      mem_addr_out    <= '0;
      core_data_out   <= '0;
      dump_sel_out    <= 1'b0;
      core_hold_out   <= 1'b0;
      trigger_out     <= 1'b0;
      trace_busy_out  <= 1'b0;
      trace_done_out  <= 1'b0;
      trace_count_out <= '0;
      overrun_out     <= 1'b0;
    end else begin
      mem_addr_out  <= prog_addr_in;
      dump_sel_out  <= ((bk_state == tbu_pkg::tbu_bk_dump) && !resume_in) ||
                       bk_fire;
      core_data_out <= dump_sel_out ? dump_data_in : prog_data_in;
      core_hold_out <= (bk_state == tbu_pkg::tbu_bk_dump) && dump_done_in
                       && !resume_in;
      trigger_out   <= trig_req;
      trace_busy_out  <= (tr_state == tbu_pkg::tbu_tr_armed) ||
                         (tr_state == tbu_pkg::tbu_tr_post);
      trace_done_out  <= (tr_state == tbu_pkg::tbu_tr_done);
      trace_count_out <= fill;
      overrun_out     <= mem_vld && !fifo_ready;
    end
  end
endmodule

//--- testbench/tbu_top_monitor.sv
/*
  checker of the trace and breakpoint unit, bound to tbu_top.
  assumes only the top module's ports; one clock, sync reset.
*/
`timescale 1ns/10ps
`include "tbu_cfg.svh"
module tbu_top_monitor (
  input wire logic                   clk_sys_in,
  input wire logic                   nrst_in,
  input wire logic                   host_reset_in,
  input wire logic [`TBU_ADDR_W-1:0] prog_addr_in,
  input wire logic                   fetch_in,
  input wire logic [7:0]             prog_data_in,
  input wire logic [7:0]             dump_data_in,
  input wire logic                   trace_now_in,
  input wire logic                   break_now_in,
  input wire logic                   step_en_in,
  input wire logic                   resume_in,
  input wire logic                   card_nrst_out,
  input wire logic [`TBU_ADDR_W-1:0] mem_addr_out,
  input wire logic [7:0]             core_data_out,
  input wire logic                   dump_sel_out,
  input wire logic                   trigger_out,
  input wire logic                   trace_busy_out,
  input wire logic                   trace_done_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  property p_trig_pulse;
    trigger_out |=> !trigger_out;
  endproperty
  a_trig_pulse: assert property (p_trig_pulse) else $error("trigger wider than one cycle");
  property p_now_trig;
    trace_now_in && !trace_busy_out |-> ##[1:2] trigger_out;
  endproperty
  a_now_trig: assert property (p_now_trig) else $error("no trigger after trace command");
  property p_break_now;
    break_now_in && !dump_sel_out |-> ##[1:2] dump_sel_out;
  endproperty
  a_break_now: assert property (p_break_now) else $error("no break after command");
  property p_dump_hold;
    dump_sel_out && !resume_in |=> dump_sel_out;
  endproperty
  a_dump_hold: assert property (p_dump_hold) else $error("break left without resume");
  property p_resume;
    dump_sel_out && resume_in |=> !dump_sel_out;
  endproperty
  a_resume: assert property (p_resume) else $error("resume not taken");
  property p_dump_data;
    $past(nrst_in) && dump_sel_out && $past(dump_sel_out) |-> core_data_out == $past(dump_data_in);
  endproperty
  a_dump_data: assert property (p_dump_data) else $error("core data not from dump memory");
  property p_prog_data;
    $past(nrst_in) && !dump_sel_out && !$past(dump_sel_out)
      |-> core_data_out == $past(prog_data_in);
  endproperty
  a_prog_data: assert property (p_prog_data) else $error("core data not from program");
  property p_addr;
    $past(nrst_in) |-> mem_addr_out == $past(prog_addr_in);
  endproperty
  a_addr: assert property (p_addr) else $error("memory address not passed on");
  property p_card;
    $past(nrst_in) |-> card_nrst_out == !$past(host_reset_in);
  endproperty
  a_card: assert property (p_card) else $error("card reset not following host");
  property p_step;
    step_en_in && fetch_in && !dump_sel_out && !resume_in |-> ##[1:2] dump_sel_out;
  endproperty
  a_step: assert property (p_step) else $error("no break on stepped fetch");
  c_trig: cover property (trigger_out);
  c_dump: cover property ($rose(dump_sel_out));
  c_done: cover property ($rose(trace_done_out));
endmodule
bind tbu_top tbu_top_monitor tbu_top_monitor_i (.clk_sys_in, .nrst_in, .host_reset_in,
  .prog_addr_in, .fetch_in, .prog_data_in, .dump_data_in, .trace_now_in, .break_now_in,
  .step_en_in, .resume_in, .card_nrst_out, .mem_addr_out, .core_data_out, .dump_sel_out,
  .trigger_out, .trace_busy_out, .trace_done_out);

//--- testbench/tbu_core_model.sv
/*
  model of the emulated core: fetches a looping address run, serves memories.
  assumes the unit's mem_addr_out and core_hold_out come back to it.
*/
`timescale 1ns/10ps
module tbu_core_model (
  input  wire logic        clk_sys_in,
  input  wire logic        nrst_in,
  input  wire logic        run_in,
  input  wire logic [10:0] loop_in,
  input  wire logic        hold_in,
  input  wire logic [10:0] mem_addr_in,
  output logic      [10:0] addr_out,
  output logic             fetch_out,
  output logic             skip_out,
  output logic      [7:0]  prog_data_out,
  output logic      [7:0]  dump_data_out
);
  logic [10:0] pc;
  assign prog_data_out = mem_addr_in[7:0] ^ 8'h5a;
  assign dump_data_out = mem_addr_in[7:0] ^ 8'hc3;
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      pc <= 11'h0;
      fetch_out <= 1'b0;
      skip_out <= 1'b0;
      addr_out <= 11'h7ff;
    end else if (run_in && !hold_in) begin
      fetch_out <= 1'b1;
      addr_out <= pc;
      skip_out <= pc[0];
      pc <= (pc + 11'h1 == loop_in) ? 11'h0 : pc + 11'h1;
    end else begin
      fetch_out <= 1'b0;
      addr_out <= ~addr_out;
    end
  end
endmodule

//--- testbench/tb_top.sv
/*
  bench of the trace and breakpoint unit: traces, breaks, step, readout.
  assumes the core model and the bound checker.
*/
`timescale 1ns/10ps
module tb_top;
  logic               clk = 0, nrst = 0, hrst = 0, step = 0, rrdy = 0;
  logic               tarm = 0, tnow = 0, barm = 0, bnow = 0, res = 0, rreq = 0;
  logic [10:0]        ta = 0, ba = 0;
  logic [3:0]         ev = 4'h0;
  logic [1:0]         te = 0, be = 0;
  logic [7:0]         tn = 0, bn = 0, pre = 0;
  tbu_pkg::tbu_cond_t tc = tbu_pkg::tbu_cond_none, bc = tbu_pkg::tbu_cond_none;
  wire  [10:0]        pa, ma;
  wire  [7:0]         pd, dd, cnt;
  wire  [15:0]        rd;
  wire                f, sk, cn, ds, hold, trg, done, rv;
  int                 n_mismatch = 0, n_checks = 0;
  logic [15:0]        q[$];
  always #2.5 clk = ~clk;
  tbu_core_model tbu_core_model_i (.clk_sys_in(clk), .nrst_in(nrst), .run_in(1'b1),
    .loop_in(11'h010), .hold_in(hold), .mem_addr_in(ma), .addr_out(pa), .fetch_out(f),
    .skip_out(sk), .prog_data_out(pd), .dump_data_out(dd));
  tbu_top tbu_top_i (.clk_sys_in(clk), .nrst_in(nrst), .host_reset_in(hrst), .prog_addr_in(pa),
    .fetch_in(f), .skip_in(sk), .ext_event_1_in(ev[0]), .ext_event_2_in(ev[1]),
    .ext_event_3_in(ev[2]), .ext_event_4_in(ev[3]), .prog_data_in(pd), .dump_data_in(dd),
    .trace_cond_in(tc), .trace_addr_in(ta), .trace_evt_in(te), .trace_cnt_in(tn),
    .pre_depth_in(pre), .trace_arm_in(tarm), .trace_now_in(tnow), .break_cond_in(bc),
    .break_addr_in(ba), .break_evt_in(be), .break_cnt_in(bn), .break_arm_in(barm),
    .break_now_in(bnow), .step_en_in(step), .resume_in(res), .dump_done_in(ds),
    .rd_req_in(rreq), .rd_ready_in(rrdy), .card_nrst_out(cn), .mem_addr_out(ma),
    .core_data_out(), .dump_sel_out(ds), .core_hold_out(hold), .trigger_out(trg),
    .trace_busy_out(), .trace_done_out(done), .trace_count_out(cnt), .rd_data_out(rd),
    .rd_valid_out(rv), .overrun_out());
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one-cycle pulse: 0 arm trace, 1 trace now, 2 arm break, 3 break now, 4 resume, 5 read
  task automatic kick(input int s);
    @(posedge clk);
    {tarm, tnow, barm, bnow, res, rreq} <= 6'h20 >> s;
    @(posedge clk);
    {tarm, tnow, barm, bnow, res, rreq} <= 6'h00;
  endtask
  // bounded wait: 0 trigger, 1 dump select, 2 trace done
  task automatic await(input int s, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(negedge clk);
      if ({trg, ds, done} >> (2 - s) & 3'h1) return;
    end
    chk("wait", 16'h0001, 16'h0000);
    conclude();
  endtask
  task automatic hits(input logic [10:0] x, input int n);
    int c;
    c = 0;
    for (int i = 0; i < 400 && trg !== 1'b1; i++) begin
      @(negedge clk);
      if (trg !== 1'b1 && f === 1'b1 && pa === x) c++;
    end
    chk("hits", 16'(n), 16'(c));
  endtask
  task automatic readout(input logic [10:0] base, input bit rel);
    logic [10:0] a;
    q.delete();
    kick(5);
    for (int i = 0; i < 1500 && q.size() < 254; i++) begin
      @(posedge clk) rrdy <= i[2];
      @(negedge clk) if (rv === 1'b1 && rrdy) q.push_back(rd);
    end
    chk("count", 16'h00fe, {8'h00, cnt});
    chk("words", 16'h00fe, 16'(q.size()));
    if (rel) base = q[0][10:0];
    foreach (q[k]) begin
      a = 11'((base + k) % 16);
      chk("entry", {ev, a[0], a}, q[k]);
    end
  endtask
  task automatic t_reset;
    chk("card_nrst", 16'h0000, {15'h0, cn});
    @(posedge clk) nrst <= 1;
    repeat (2) @(posedge clk);
    @(negedge clk) chk("card_nrst", 16'h0001, {15'h0, cn});
    @(posedge clk) hrst <= 1;
    repeat (2) @(posedge clk);
    @(negedge clk) chk("card_nrst", 16'h0000, {15'h0, cn});
    @(posedge clk) hrst <= 0;
  endtask
  task automatic t_trace;
    ev <= 4'h9;
    kick(1);
    await(0, 4);
    await(2, 400);
    readout(11'h000, 1'b1);
    tc <= tbu_pkg::tbu_cond_addr;
    ta <= 11'h005;
    tn <= 8'h02;
    pre <= 8'h0a;
    kick(0);
    hits(11'h005, 3);
    await(2, 400);
    readout(11'h00b, 1'b0);
    tc <= tbu_pkg::tbu_cond_event;
    te <= 2'h1;
    tn <= 8'h00;
    ev <= 4'h0;
    kick(0);
    repeat (20) @(posedge clk);
    chk("early_trig", 16'h0000, {15'h0, trg});
    ev <= 4'h5;
    await(0, 6);
    await(2, 400);
  endtask
  task automatic t_break;
    bc <= tbu_pkg::tbu_cond_event;
    be <= 2'h2;
    ev <= 4'h0;
    kick(2);
    repeat (20) @(posedge clk);
    chk("early_break", 16'h0000, {15'h0, ds});
    ev <= 4'h2;
    await(0, 6);
    await(1, 3);
    repeat (20) @(posedge clk);
    @(negedge clk) chk("held", 16'h0001, {15'h0, ds});
    chk("core_hold", 16'h0001, {15'h0, hold});
    kick(4);
    @(negedge clk) chk("resumed", 16'h0000, {15'h0, ds});
    chk("core_free", 16'h0000, {15'h0, hold});
    bc <= tbu_pkg::tbu_cond_addr;
    ba <= 11'h007;
    bn <= 8'h01;
    kick(2);
    hits(11'h007, 2);
    await(1, 3);
    kick(4);
    kick(3);
    await(1, 4);
    kick(4);
  endtask
  task automatic t_step;
    step <= 1;
    await(1, 6);
    kick(4);
    await(1, 6);
    step <= 0;
    kick(4);
    repeat (6) @(posedge clk);
    @(negedge clk) chk("step_off", 16'h0000, {15'h0, ds});
  endtask
  initial begin
    repeat (4) @(posedge clk);
    t_reset();
    t_trace();
    t_break();
    t_step();
    conclude();
  end
endmodule
